// File: mode_reg_decode.sv
`timescale 1ns/1ps
`include "mode_regs.svh"
module mode_reg_decode
    import mode_pkg::*;
#(
    parameter int ADDR_W = 15,
    parameter int LAT_W  = 4
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [2:0]        bank,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [LAT_W-1:0]  cas_latency,
    input  wire logic              rd_cmd,
    input  wire logic              wr_cmd,
    input  wire logic              rd_data_active,
    input  wire logic              level_feedback,
    input  wire logic              write_burst,
    input  wire logic              self_refresh,
    output logic                   int_rd_q,
    output logic                   int_wr_q,
    output logic                   dq_oe_q,
    output logic                   dyn_odt_q,
    output logic [1:0]             dyn_odt_code_q,
    output logic                   level_mode_q,
    output logic                   term_strobe_enable_q,
    output logic                   output_off_q,
    output logic [1:0]             additive_latency_q,
    output logic [3:0]             write_cas_delay_q,
    output logic                   write_cas_rsvd_q,
    output logic [7:0]             bank_keep_q,
    output logic                   auto_temp_refresh_q,
    output logic                   extended_temp_refresh_q,
    output logic                   refresh_adjust_q
);
    // Elaboration checks: bit 12 must exist and the latency port must hold CL
    if (ADDR_W < 13) begin : g_bad_addr
        $error("mode_reg_decode: ADDR_W must be at least 13");
    end
    if (LAT_W < 3) begin : g_bad_lat
        $error("mode_reg_decode: LAT_W must hold the CAS latency");
    end

    // ------------------------------------------------------------
    // Pin synchronisers: command pins come from the link side
    // ------------------------------------------------------------
    localparam int PW = ADDR_W + 9;
    logic [PW-1:0] pin_meta_q, pin_sync_q, pin_raw;
    assign pin_raw = {cs_n, ras_n, cas_n, we_n, bank, addr, rd_cmd, wr_cmd};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_meta_q <= {4'hF, {(PW-4){1'b0}}};
            pin_sync_q <= {4'hF, {(PW-4){1'b0}}};
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    logic              s_cs_n, s_ras_n, s_cas_n, s_we_n, s_rd, s_wr;
    logic [2:0]        s_bank;
    logic [ADDR_W-1:0] s_addr;
    assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_bank, s_addr, s_rd, s_wr} = pin_sync_q;

    // Mode register set decode: all four strobes low, bank picks the register
    // Strobes are arguments so the continuous assignments see them change
    function automatic logic mrs_hit(input logic [3:0] strobes_n, input logic [2:0] bk,
                                     input logic [2:0] want);
        mrs_hit = (strobes_n == 4'h0) && (bk == want);
    endfunction : mrs_hit

    logic [3:0] s_cmd_n;
    logic       set_one, set_two;
    assign s_cmd_n = {s_cs_n, s_ras_n, s_cas_n, s_we_n};
    assign set_one = mrs_hit(s_cmd_n, s_bank, `BANK_MODE_ONE);
    assign set_two = mrs_hit(s_cmd_n, s_bank, `BANK_MODE_TWO);

    // ------------------------------------------------------------
    // Register fields; each holds until its own set command
    // ------------------------------------------------------------
    logic [1:0] addlat_q, addlat_d, rtt_q, rtt_d;
    logic       lvl_q, lvl_d, strobe_term_q, strobe_term_d, qoff_q, qoff_d;
    logic       auto_temp_q, auto_temp_d, ext_temp_q, ext_temp_d;
    logic [2:0] wr_delay_q, wr_delay_d, part_refresh_q, part_refresh_d;

    always_comb begin
        {addlat_d, lvl_d, strobe_term_d, qoff_d} = {addlat_q, lvl_q, strobe_term_q, qoff_q};
        {wr_delay_d, part_refresh_d} = {wr_delay_q, part_refresh_q};
        {auto_temp_d, ext_temp_d, rtt_d} = {auto_temp_q, ext_temp_q, rtt_q};
        if (set_one) begin
            addlat_d      = s_addr[`ONE_ADDLAT_LO +: 2];
            lvl_d         = s_addr[`ONE_LEVEL_BIT];
            strobe_term_d = s_addr[`ONE_STROBE_TERM_BIT];
            qoff_d        = s_addr[`ONE_QOFF_BIT];
        end
        if (set_two) begin
            part_refresh_d = s_addr[`TWO_PART_REFRESH_LO +: 3];
            wr_delay_d     = s_addr[`TWO_WR_DELAY_LO +: 3];
            auto_temp_d    = s_addr[`TWO_AUTO_TEMP_BIT];
            ext_temp_d     = s_addr[`TWO_EXT_TEMP_BIT];
            rtt_d          = s_addr[`TWO_RTT_LO +: 2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            addlat_q       <= `ADDLAT_RESET;
            lvl_q          <= 1'b0;
            strobe_term_q  <= 1'b0;
            qoff_q         <= 1'b0;
            wr_delay_q     <= `WR_DELAY_RESET;
            part_refresh_q <= `PART_REFRESH_RESET;
            auto_temp_q    <= 1'b0;
            ext_temp_q     <= 1'b0;
            rtt_q          <= `RTT_RESET;
        end else begin
            addlat_q       <= addlat_d;
            lvl_q          <= lvl_d;
            strobe_term_q  <= strobe_term_d;
            qoff_q         <= qoff_d;
            wr_delay_q     <= wr_delay_d;
            part_refresh_q <= part_refresh_d;
            auto_temp_q    <= auto_temp_d;
            ext_temp_q     <= ext_temp_d;
            rtt_q          <= rtt_d;
        end
    end

    // ------------------------------------------------------------
    // Additive latency and internal command delay
    // ------------------------------------------------------------
    // Reserved code 11 is treated as zero so commands never vanish
    logic [LAT_W-1:0] addlat_cycles;
    always_comb begin
        unique case (additive_latency_t'(addlat_q))
            ADDLAT_CL_MINUS_ONE: addlat_cycles = cas_latency - LAT_W'(1);
            ADDLAT_CL_MINUS_TWO: addlat_cycles = cas_latency - LAT_W'(2);
            ADDLAT_ZERO:         addlat_cycles = '0;
            ADDLAT_RESERVED:     addlat_cycles = '0;
        endcase
    end

    logic dly_rd, dly_wr;
    latency_delay #(
        .DEPTH (1 << LAT_W)
    ) u_addlat_delay (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_rd     (s_rd),
        .in_wr     (s_wr),
        .delay_sel (addlat_cycles),
        .out_rd    (dly_rd),
        .out_wr    (dly_wr)
    );

    // Partial refresh bank mask, one bit per kept bank
    // Codes 101 and 110 both keep the top two banks; the table is unclear for 101
    function automatic logic [7:0] keep_mask(input logic [2:0] code);
        unique case (code)
            3'h0:    keep_mask = 8'hFF;
            3'h1:    keep_mask = 8'h0F;
            3'h2:    keep_mask = 8'h03;
            3'h3:    keep_mask = 8'h01;
            3'h4:    keep_mask = 8'hFC;
            3'h5:    keep_mask = 8'hC0;
            3'h6:    keep_mask = 8'hC0;
            3'h7:    keep_mask = 8'h80;
        endcase
    endfunction : keep_mask

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    logic       oe_d, odt_d, rsvd_d;
    logic [7:0] keep_d;
    always_comb begin
        oe_d   = !qoff_q && (rd_data_active || (lvl_q && level_feedback));
        odt_d  = !lvl_q && write_burst && (rtt_q != RTT_WR_OFF) && (rtt_q != RTT_WR_RSVD);
        rsvd_d = (wr_delay_q > `WR_DELAY_MAX_CODE);
        keep_d = self_refresh ? keep_mask(part_refresh_q) : 8'hFF;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            int_rd_q <= 1'b0;
            int_wr_q <= 1'b0;
            dq_oe_q <= 1'b0;
            dyn_odt_q <= 1'b0;
            dyn_odt_code_q <= `RTT_RESET;
            level_mode_q <= 1'b0;
            term_strobe_enable_q <= 1'b0;
            output_off_q <= 1'b0;
            additive_latency_q <= `ADDLAT_RESET;
            write_cas_delay_q <= 4'(`WR_DELAY_BASE);
            write_cas_rsvd_q <= 1'b0;
            bank_keep_q <= 8'hFF;
            auto_temp_refresh_q <= 1'b0;
            extended_temp_refresh_q <= 1'b0;
            refresh_adjust_q <= 1'b0;
        end else begin
            int_rd_q <= dly_rd;
            int_wr_q <= dly_wr;
            dq_oe_q <= oe_d;
            dyn_odt_q <= odt_d;
            dyn_odt_code_q <= rtt_q;
            level_mode_q <= lvl_q;
            term_strobe_enable_q <= strobe_term_q;
            output_off_q <= qoff_q;
            additive_latency_q <= addlat_q;
            write_cas_delay_q <= 4'(`WR_DELAY_BASE) + {1'b0, wr_delay_q};
            write_cas_rsvd_q <= rsvd_d;
            bank_keep_q <= keep_d;
            auto_temp_refresh_q <= auto_temp_q;
            extended_temp_refresh_q <= ext_temp_q;
            refresh_adjust_q <= auto_temp_q | ext_temp_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_qoff_set;
        qoff_q;
    endsequence

    chk_qoff_blocks_oe: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_qoff_set ##1 qoff_q |-> !dq_oe_q)
        else $error("outputs enabled while output disable set");

    chk_read_drives_oe: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!qoff_q && rd_data_active) |=> dq_oe_q)
        else $error("read data did not enable outputs");

    chk_level_no_odt: assert property (@(posedge sys_clk) disable iff (sys_rst)
        lvl_q |=> !dyn_odt_q)
        else $error("dynamic termination during write leveling");

    chk_odt_on_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!lvl_q && write_burst && rtt_q == 2'h1) |=> dyn_odt_q)
        else $error("dynamic termination missing in write burst");

    chk_one_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
        set_one |=> lvl_q == $past(s_addr[`ONE_LEVEL_BIT]) ##1 level_mode_q == $past(lvl_q))
        else $error("first register not loaded");

    chk_two_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
        set_two |=> ##1 write_cas_delay_q == 4'(`WR_DELAY_BASE) + {1'b0, $past(s_addr[5:3], 2)})
        else $error("write latency not loaded");

    chk_regs_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !set_one && !set_two |=> $stable(addlat_q) && $stable(wr_delay_q) && $stable(rtt_q))
        else $error("register changed without set command");

    chk_addlat_zero_pass: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (addlat_q == 2'h0 && s_wr) |=> int_wr_q)
        else $error("write not passed with zero latency");

    chk_full_array: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (part_refresh_q == 3'h0 || !self_refresh) |=> bank_keep_q == 8'hFF)
        else $error("banks dropped with full array");

    chk_auto_temp_adjust: assert property (@(posedge sys_clk) disable iff (sys_rst)
        auto_temp_q |=> refresh_adjust_q)
        else $error("auto refresh did not adjust");
endmodule : mode_reg_decode

// File: mode_regs.svh
`ifndef MODE_REGS_SVH
`define MODE_REGS_SVH
// Operation
// - Accepted reads and writes are held for the additive latency before going internal.
// - Additive latency code 00 is zero, 01 is CL-1, 10 is CL-2, 11 reserved.
// - First register bit 7 selects write leveling mode when set.
// - With output disable clear, outputs drive during reads and leveling feedback.
// - With output disable set, DQ and strobe outputs stay disabled always.
// - Second register write is all command strobes low with bank 010.
// - Partial refresh code limits banks kept in self refresh; 000 keeps all.
// - Outside self refresh every bank is preserved given regular refresh.
// - Write latency code 000 to 101 gives 5 to 10 cycles; others reserved.
// - Auto temperature refresh bit set adjusts automatically; else range bit governs.
// - Dynamic termination code 00 off, 01 is RZQ/4, 10 is RZQ/2.
// - Dynamic termination applies during write bursts even without nominal termination.
// - Write leveling mode suppresses dynamic termination switching.
// - First register write is all command strobes low with bank 001.

// ------------------------------------------------------------
// Bank codes and field positions
// ------------------------------------------------------------
`define BANK_MODE_ONE         3'h1
`define BANK_MODE_TWO         3'h2
`define ONE_ADDLAT_LO         3
`define ONE_LEVEL_BIT         7
`define ONE_STROBE_TERM_BIT   11
`define ONE_QOFF_BIT          12
`define TWO_PART_REFRESH_LO   0
`define TWO_WR_DELAY_LO       3
`define TWO_AUTO_TEMP_BIT     6
`define TWO_EXT_TEMP_BIT      7
`define TWO_RTT_LO            9
`define WR_DELAY_BASE         5
`define WR_DELAY_MAX_CODE     3'h5
`define ADDLAT_RESET          2'h0
`define WR_DELAY_RESET        3'h0
`define RTT_RESET             2'h0
`define PART_REFRESH_RESET    3'h0
`endif

// File: mode_pkg.sv
package mode_pkg;
    typedef enum logic [1:0] {
        ADDLAT_ZERO,
        ADDLAT_CL_MINUS_ONE,
        ADDLAT_CL_MINUS_TWO,
        ADDLAT_RESERVED
    } additive_latency_t;

    typedef enum logic [1:0] {
        RTT_WR_OFF,
        RTT_WR_RZQ4,
        RTT_WR_RZQ2,
        RTT_WR_RSVD
    } rtt_wr_t;
endpackage : mode_pkg

// File: latency_delay.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Variable delay line: a pulse leaves after delay_sel cycles
// ------------------------------------------------------------
module latency_delay #(
    parameter int DEPTH = 16
) (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     in_rd,
    input  wire logic                     in_wr,
    input  wire logic [$clog2(DEPTH)-1:0] delay_sel,
    output logic                          out_rd,
    output logic                          out_wr
);
    // Elaboration check: the shift below needs at least two stages
    if (DEPTH < 2) begin : g_bad_depth
        $error("latency_delay: DEPTH must be at least 2");
    end

    logic [DEPTH-1:0] rd_q, rd_d;
    logic [DEPTH-1:0] wr_q, wr_d;

    // Shift; stage 0 is one cycle late, zero delay bypasses the line
    always_comb begin
        rd_d = {rd_q[DEPTH-2:0], in_rd};
        wr_d = {wr_q[DEPTH-2:0], in_wr};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_q <= '0;
            wr_q <= '0;
        end else begin
            rd_q <= rd_d;
            wr_q <= wr_d;
        end
    end

    // Pick tap; a mid-run change of delay may drop or repeat an in-flight command
    always_comb begin
        if (delay_sel == '0) begin
            out_rd = in_rd;
            out_wr = in_wr;
        end else begin
            out_rd = rd_q[delay_sel - 1'b1];
            out_wr = wr_q[delay_sel - 1'b1];
        end
    end
endmodule : latency_delay

// File: mode_ctrl_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Controller side: issues register set commands
// ------------------------------------------------------------
module mode_ctrl_model (
    input  wire logic        sys_clk,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [2:0]       bank,
    output logic [14:0]      addr
);
    // Idle strobes high; lines show the inverse so a stale value never passes
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        bank = 3'h0;
        addr = 15'h0000;
    end

    // One command cycle; skip_cs keeps chip select high for a refused command
    task automatic set_mode(input logic [2:0] b, input logic [14:0] a, input logic skip_cs);
        @(posedge sys_clk);
        cs_n <= skip_cs;
        {ras_n, cas_n, we_n} <= 3'h0;
        bank <= b;
        addr <= {2'h0, a[12:0]};
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'hF;
        bank <= ~b;
        addr <= ~{2'h0, a[12:0]};
    endtask : set_mode
endmodule : mode_ctrl_model

// File: sdram_mode_register_decode_test.sv
`timescale 1ns/1ps
module sdram_mode_register_decode_test;
    import mode_pkg::*;
    logic        sys_clk = 1'b0;
    logic        sys_rst, rd_cmd, wr_cmd, rd_data_active, level_feedback;
    logic        write_burst, self_refresh, cs_n, ras_n, cas_n, we_n;
    logic        int_rd_q, int_wr_q, dq_oe_q, dyn_odt_q, level_mode_q;
    logic        term_strobe_enable_q, output_off_q, write_cas_rsvd_q;
    logic        auto_temp_refresh_q, extended_temp_refresh_q, refresh_adjust_q;
    logic [1:0]  dyn_odt_code_q, additive_latency_q;
    logic [2:0]  bank;
    logic [3:0]  cas_latency, write_cas_delay_q;
    logic [7:0]  bank_keep_q;
    logic [14:0] addr, a1, a2;
    logic [31:0] seed = 32'h9196E2A7;
    logic [31:0] r;
    int          miscompares = 0;
    int          checked = 0;
    int          cl, e_addlat, e_lvl, e_strobe_term, e_qoff, e_part_refresh, e_wr_delay;
    int          e_auto_temp, e_ext_temp, e_rtt;
    int          keep_tab[8] = '{255, 15, 3, 1, 252, 192, 192, 128};

    always #2 sys_clk = ~sys_clk;

    mode_ctrl_model ctrl_i (.sys_clk(sys_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
                            .we_n(we_n), .bank(bank), .addr(addr));

    mode_reg_decode mode_reg_decode_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .bank(bank), .addr(addr), .cas_latency(cas_latency),
        .rd_cmd(rd_cmd), .wr_cmd(wr_cmd), .rd_data_active(rd_data_active),
        .level_feedback(level_feedback), .write_burst(write_burst),
        .self_refresh(self_refresh), .int_rd_q(int_rd_q), .int_wr_q(int_wr_q),
        .dq_oe_q(dq_oe_q), .dyn_odt_q(dyn_odt_q), .dyn_odt_code_q(dyn_odt_code_q),
        .level_mode_q(level_mode_q), .term_strobe_enable_q(term_strobe_enable_q),
        .output_off_q(output_off_q), .additive_latency_q(additive_latency_q),
        .write_cas_delay_q(write_cas_delay_q), .write_cas_rsvd_q(write_cas_rsvd_q),
        .bank_keep_q(bank_keep_q), .auto_temp_refresh_q(auto_temp_refresh_q),
        .extended_temp_refresh_q(extended_temp_refresh_q),
        .refresh_adjust_q(refresh_adjust_q)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] next_rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rnd

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("miscompares=%0d checked=%0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // Fields stand until the next set of the same register
    task automatic check_fields();
        check(8'(level_mode_q), 8'(e_lvl));
        check(8'(term_strobe_enable_q), 8'(e_strobe_term));
        check(8'(output_off_q), 8'(e_qoff));
        check(8'(additive_latency_q), 8'(e_addlat));
        if (e_wr_delay < 6) check(8'(write_cas_delay_q), 8'(5 + e_wr_delay));
        check(8'(write_cas_rsvd_q), 8'(e_wr_delay > 5));
        check(8'(auto_temp_refresh_q), 8'(e_auto_temp));
        check(8'(extended_temp_refresh_q), 8'(e_ext_temp));
        check(8'(refresh_adjust_q), 8'(e_auto_temp | e_ext_temp));
        check(8'(dyn_odt_code_q), 8'(e_rtt));
    endtask : check_fields

    // One command pulse; count edges until the internal command appears
    // Two synchroniser stages and the output flop give 3 edges before the latency
    task automatic measure(input bit wr);
        int   n;
        logic seen;
        int   addlat;
        addlat = (e_addlat == 1) ? cl - 1 : (e_addlat == 2) ? cl - 2 : 0;
        @(posedge sys_clk);
        if (wr) wr_cmd <= 1'b1;
        else rd_cmd <= 1'b1;
        @(posedge sys_clk);
        rd_cmd <= 1'b0;
        wr_cmd <= 1'b0;
        n = 1;
        seen = 1'b0;
        while (seen !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
            seen = wr ? int_wr_q : int_rd_q;
        end
        if (seen !== 1'b1) begin
            miscompares++;
            complete_run();
        end else check(8'(n), 8'(3 + addlat));
    endtask : measure

    // Level inputs held steady, then the enables and kept banks are compared
    task automatic stim_levels(input logic [31:0] v);
        @(posedge sys_clk);
        rd_data_active <= v[0];
        level_feedback <= v[1];
        write_burst    <= v[2];
        self_refresh   <= v[3];
        repeat (3) @(posedge sys_clk);
        #1;
        check(8'(dq_oe_q), 8'(!e_qoff && (v[0] || (v[1] && e_lvl))));
        check(8'(dyn_odt_q), 8'(v[2] && e_rtt != 0 && !e_lvl));
        check(bank_keep_q, v[3] ? 8'(keep_tab[e_part_refresh]) : 8'hFF);
    endtask : stim_levels

    // ------------------------------------------------------------
    // Main sequence: every partial refresh and write latency code in turn
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        {rd_cmd, wr_cmd, rd_data_active, level_feedback} = 4'h0;
        {write_burst, self_refresh} = 2'h0;
        cas_latency = 4'h5;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            r = next_rnd();
            cl = 5 + int'(r[31:28]) % 7;
            cas_latency <= 4'(cl);
            e_addlat = i % 3; // Code 11 is never programmed
            e_lvl = int'(r[7]);
            e_strobe_term = int'(r[11]);
            e_qoff = int'(r[12]);
            a1 = r[14:0];
            a1[4:3] = 2'(e_addlat);
            e_part_refresh = i;
            e_wr_delay = i; // Sweeps the controller speed bands and reserved codes
            e_auto_temp = int'(r[16]);
            e_ext_temp = int'(r[17]);
            e_rtt = i % 3;
            a2 = {4'h0, 2'(e_rtt), 1'b0, r[17], r[16], 3'(i), 3'(i)};
            ctrl_i.set_mode(3'h1, a1, 1'b0);
            ctrl_i.set_mode(3'h2, a2, 1'b0);
            repeat (6) @(posedge sys_clk);
            #1;
            check_fields();
            measure(1'b0);
            measure(1'b1);
            repeat (4) stim_levels(next_rnd());
            stim_levels(32'h0);
            // Other bank codes and a deselected command must leave fields alone
            ctrl_i.set_mode(3'(4 + i % 4), ~a1, 1'b0);
            ctrl_i.set_mode(3'h2, ~a2, 1'b1);
            repeat (6) @(posedge sys_clk);
            #1;
            check_fields();
        end
        complete_run();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end
endmodule : sdram_mode_register_decode_test
